// file: pkg/evtcnt_pkg.sv
// ****************************************************************
// Event counter channel shared definitions
// ****************************************************************
package evtcnt_pkg;

   // ****************************************************************
   // Register map (byte addresses on the APB side)
   // ****************************************************************
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] COUNT_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;

   // ****************************************************************
   // Reset values and counter limits
   // ****************************************************************
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_MIN = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [9:0] CTRL_RST = 10'h000;
   localparam logic [2:0] WORD_PAD = 3'h0;

   // ****************************************************************
   // Count source select codes
   // ****************************************************************
   localparam logic [1:0] TRIG_PIN = 2'h0;
   localparam logic [1:0] TRIG_B2 = 2'h1;
   localparam logic [1:0] TRIG_PREV = 2'h2;
   localparam logic [1:0] TRIG_NEXT = 2'h3;

   // Channels from this index upward own the two-phase decoder
   localparam int unsigned FIRST_TWO_PHASE_CH = 2;
   localparam int unsigned X4_SEL_CH = 3;
   localparam int unsigned X4_FIXED_CH = 4;

   // Control word, bit 0 is run, bit 9 is x4 select
   typedef struct packed {
      logic x4_sel;
      logic two_phase;
      logic rise_edge;
      logic [1:0] trig_sel;
      logic pulse_en;
      logic free_run;
      logic dir_from_pin;
      logic up;
      logic run;
   } ctrl_t;

   // Status word, bit 0 is run flag echo
   typedef struct packed {
      logic pin_level;
      logic counting;
      logic running;
   } stat_t;

   // Run state, Gray coded along idle, armed, counting
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_COUNT = 2'h3
   } run_st_t;

   // Phase decoder mode
   typedef enum logic [1:0] {
      PH_OFF = 2'h0,
      PH_NORMAL = 2'h1,
      PH_X4 = 2'h3
   } phase_mode_t;

   // Two phase inputs: a on the event pin, b on the out/dir pin
   typedef struct packed {
      logic a;
      logic b;
   } phase_t;

endpackage

// file: src/phase_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-phase pulse decoder
// ****************************************************************
module phase_decoder (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Mode and phases
   input wire evtcnt_pkg::phase_mode_t mode,
   input wire evtcnt_pkg::phase_t ph,
   // Count strobes
   output logic inc,
   output logic dec
);
   evtcnt_pkg::phase_t prev_q;
   logic a_rise, a_fall, b_rise, b_fall, up4, dn4, n_inc, n_dec;

   // Previous phase levels for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= '0;
      end else if (ce) begin
         prev_q <= ph;
      end
   end

   assign a_rise = ph.a & ~prev_q.a;
   assign a_fall = ~ph.a & prev_q.a;
   assign b_rise = ph.b & ~prev_q.b;
   assign b_fall = ~ph.b & prev_q.b;

   // Normal: a edges counted only while b is high
   assign n_inc = a_rise & ph.b;
   assign n_dec = a_fall & ph.b;

   // Times four: every edge, direction from which phase leads
   assign up4 = (a_rise & ph.b) | (a_fall & ~ph.b) |
                (b_rise & ~ph.a) | (b_fall & ph.a);
   assign dn4 = (a_rise & ~ph.b) | (a_fall & ph.b) |
                (b_rise & ph.a) | (b_fall & ~ph.a);

   // In times four, both phases moving at once is ambiguous, so it is dropped
   assign inc = (mode == evtcnt_pkg::PH_X4) ? (up4 & ~dn4) :
                (mode == evtcnt_pkg::PH_NORMAL) ? n_inc : 1'b0;
   assign dec = (mode == evtcnt_pkg::PH_X4) ? (dn4 & ~up4) :
                (mode == evtcnt_pkg::PH_NORMAL) ? n_dec : 1'b0;

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_normal_gate: assert property (@(posedge clk)
      disable iff (!rst_n)
      (mode == evtcnt_pkg::PH_NORMAL && !ph.b) |-> !inc && !dec)
      else $error("normal decode counted while b low");
   chk_x4_lead: assert property (@(posedge clk)
      disable iff (!rst_n)
      (mode == evtcnt_pkg::PH_X4 && $past(ce) && ph.b && $rose(ph.a)
       && $stable(ph.b)) |-> inc)
      else $error("x4 decode missed up edge");
endmodule
`default_nettype wire

// file: src/event_counter.sv
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module event_counter #(
   parameter int unsigned CH = 3,
   parameter int unsigned CNT_W = 16
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event input pin
   input wire logic event_input_pin,
   // Pulse out or direction pin, three signals
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // Wrap pulses of neighbouring timers
   input wire logic b2_wrap,
   input wire logic prev_wrap,
   input wire logic next_wrap,
   // Overflow or underflow request pulse
   output logic wrap_irq
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   evtcnt_pkg::ctrl_t ctrl_q, ctrl_d;
   evtcnt_pkg::stat_t stat_w;
   evtcnt_pkg::run_st_t st_q, st_d;
   evtcnt_pkg::phase_mode_t ph_mode;
   evtcnt_pkg::phase_t ph_w;
   logic [CNT_W-1:0] cnt_q, cnt_d, reload_q, reload_d, wdata_w;
   logic [CNT_W-1:0] cnt_inc, cnt_dec;
   logic [31:0] prdata_q, rdata_w;
   logic pready_q, pslverr_q, pout_q, pout_d, oe_q, irq_q, pin_q;
   logic pin_prev_q, pin_edge, src_pulse, ph_inc, ph_dec;
   logic tp_on, x4_on, evt, up_w, wrap, underflow;
   logic acc, wr, rd, hit_ctrl, hit_cnt, hit_stat, hit_any;
   logic wr_ctrl, wr_cnt, early;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   // One wait state: pready rises the cycle after the access phase
   // opens, and the transfer completes at the edge ending that cycle
   assign acc = psel & penable & pready_q;
   assign wr = acc & pwrite;
   assign rd = psel & penable & ~pready_q & ~pwrite;
   assign hit_ctrl = (paddr == evtcnt_pkg::CTRL_OFS);
   assign hit_cnt = (paddr == evtcnt_pkg::COUNT_OFS);
   assign hit_stat = (paddr == evtcnt_pkg::STAT_OFS);
   assign hit_any = hit_ctrl | hit_cnt | hit_stat;
   assign wr_ctrl = wr & hit_ctrl;
   assign wr_cnt = wr & hit_cnt;
   assign wdata_w = pwdata[CNT_W-1:0];

   // Read mux, counter read returns the live count
   assign stat_w = '{pin_level: pout_q,
                     counting: (st_q == evtcnt_pkg::ST_COUNT),
                     running: ctrl_q.run};
   assign rdata_w = hit_ctrl ? {22'h000000, ctrl_q} :
                    hit_cnt ? {{(32-CNT_W){1'b0}}, cnt_q} :
                    hit_stat ? {29'h00000000, stat_w} :
                    32'h00000000;

   // Bus handshake and read data registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else if (ce) begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~hit_any;
         if (rd) begin
            prdata_q <= rdata_w;
         end
      end
   end

   // ****************************************************************
   // Control register
   // ****************************************************************
   // Two-phase bits are forced low on channels without the decoder,
   // so software sees them read back as zero there
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = evtcnt_pkg::ctrl_t'(pwdata[9:0]);
         if (CH < evtcnt_pkg::FIRST_TWO_PHASE_CH) begin
            ctrl_d.two_phase = 1'b0;
         end
         if (CH != evtcnt_pkg::X4_SEL_CH) begin
            ctrl_d.x4_sel = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= evtcnt_pkg::CTRL_RST;
      end else if (ce) begin
         ctrl_q <= ctrl_d;
      end
   end

   // ****************************************************************
   // Count source
   // ****************************************************************
   // Both pins become phases when two-phase processing is on
   assign tp_on = ctrl_q.two_phase;
   assign x4_on = (CH == evtcnt_pkg::X4_FIXED_CH) |
                  ((CH == evtcnt_pkg::X4_SEL_CH) & ctrl_q.x4_sel);
   assign ph_mode = !tp_on ? evtcnt_pkg::PH_OFF :
                    x4_on ? evtcnt_pkg::PH_X4 :
                    evtcnt_pkg::PH_NORMAL;
   assign ph_w = '{a: event_input_pin, b: pin_in};

   phase_decoder u_phase (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .mode(ph_mode),
      .ph(ph_w),
      .inc(ph_inc),
      .dec(ph_dec)
   );

   // Edge of the event pin with software chosen polarity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_q <= 1'b0;
      end else if (ce) begin
         pin_prev_q <= event_input_pin;
      end
   end

   assign pin_edge = ctrl_q.rise_edge ?
                     (event_input_pin & ~pin_prev_q) :
                     (~event_input_pin & pin_prev_q);

   // Pin only on code 00; other codes pick a neighbour wrap, where
   // prev is channel i-1 (4 for 0) and next is i+1 (0 for 4)
   assign src_pulse =
      (ctrl_q.trig_sel == evtcnt_pkg::TRIG_PIN) ? pin_edge :
      (ctrl_q.trig_sel == evtcnt_pkg::TRIG_B2) ? b2_wrap :
      (ctrl_q.trig_sel == evtcnt_pkg::TRIG_PREV) ? prev_wrap :
      next_wrap;

   // Direction: phase relation, pin level, or software flag
   assign up_w = tp_on ? ph_inc :
                 ctrl_q.dir_from_pin ? pin_in :
                 ctrl_q.up;
   assign evt = ctrl_q.run &
                (tp_on ? (ph_inc | ph_dec) : src_pulse);

   // ****************************************************************
   // Counter and reload register
   // ****************************************************************
   assign cnt_inc = cnt_q + CNT_W'(1);
   assign cnt_dec = cnt_q - CNT_W'(1);
   assign underflow = evt & ~up_w & (cnt_q == CNT_W'(0));
   assign wrap = underflow |
                 (evt & up_w & (cnt_q == {CNT_W{1'b1}}));
   // Writes reach the counter until the first event is counted
   assign early = ~ctrl_q.run | (st_q != evtcnt_pkg::ST_COUNT);

   // A write before the first event beats a same-cycle event
   always_comb begin
      reload_d = reload_q;
      cnt_d = cnt_q;
      if (wr_cnt) begin
         reload_d = wdata_w;
      end
      if (wr_cnt && early) begin
         cnt_d = wdata_w;
      end else if (wrap && !ctrl_q.free_run) begin
         cnt_d = reload_q;
      end else if (evt) begin
         cnt_d = up_w ? cnt_inc : cnt_dec;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= evtcnt_pkg::COUNT_RST;
         reload_q <= evtcnt_pkg::COUNT_RST;
      end else if (ce) begin
         cnt_q <= cnt_d;
         reload_q <= reload_d;
      end
   end

   // ****************************************************************
   // Run state
   // ****************************************************************
   // Armed after start, counting once the first event has landed
   always_comb begin
      st_d = st_q;
      case (st_q)
         evtcnt_pkg::ST_IDLE: begin
            // An event in the very first run cycle is the first event
            if (evt) begin
               st_d = evtcnt_pkg::ST_COUNT;
            end else if (ctrl_q.run) begin
               st_d = evtcnt_pkg::ST_ARMED;
            end
         end
         evtcnt_pkg::ST_ARMED: begin
            if (!ctrl_q.run) begin
               st_d = evtcnt_pkg::ST_IDLE;
            end else if (evt) begin
               st_d = evtcnt_pkg::ST_COUNT;
            end
         end
         evtcnt_pkg::ST_COUNT: begin
            if (!ctrl_q.run) begin
               st_d = evtcnt_pkg::ST_IDLE;
            end
         end
         default: begin
            st_d = evtcnt_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= evtcnt_pkg::ST_IDLE;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // Pulse output and request
   // ****************************************************************
   // Pin is only driven as pulse output; as dir or phase input it
   // is left undriven
   assign pout_d = !ctrl_q.run ? 1'b0 :
                   underflow ? ~pout_q :
                   pout_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pout_q <= 1'b0;
         pin_q <= 1'b0;
         oe_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (ce) begin
         pout_q <= pout_d;
         pin_q <= pout_d & ctrl_d.pulse_en;
         oe_q <= ctrl_q.pulse_en & ~ctrl_q.dir_from_pin & ~tp_on;
         irq_q <= wrap;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pin_out = pin_q;
   assign pin_oe = oe_q;
   assign wrap_irq = irq_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_stop_hold: assert property (ce && !ctrl_q.run && !wr_cnt
      |=> $stable(cnt_q))
      else $error("counter moved while stopped");
   chk_reload_wrap: assert property (ce && wrap && !wr_cnt
      && !ctrl_q.free_run |=> cnt_q == $past(reload_q))
      else $error("reload missing on wrap");
   chk_free_wrap: assert property (ce && wrap && !wr_cnt
      && ctrl_q.free_run && up_w |=> cnt_q == CNT_W'(0))
      else $error("free run did not roll over");
   chk_read_count: assert property (ce && rd && hit_cnt
      |=> prdata == {{(32-CNT_W){1'b0}}, $past(cnt_q)})
      else $error("count read wrong");
   chk_write_early: assert property (ce && wr_cnt && early
      |=> cnt_q == $past(wdata_w) && reload_q == $past(wdata_w))
      else $error("early write not loaded");
   chk_write_late: assert property (ce && wr_cnt && !early && !evt
      |=> $stable(cnt_q) && reload_q == $past(wdata_w))
      else $error("late write touched counter");
   chk_pulse_low: assert property (ce && !ctrl_q.run
      |=> !pout_q && !pin_out)
      else $error("pulse pin not low when stopped");
   chk_pulse_flip: assert property (ce && underflow && ctrl_q.run
      |=> pout_q != $past(pout_q))
      else $error("pulse pin missed underflow");
   chk_trig_src: assert property ($past(ce) && ctrl_q.run && !tp_on
      && ctrl_q.trig_sel == evtcnt_pkg::TRIG_PIN
      |-> evt == (ctrl_q.rise_edge ? $rose(event_input_pin) :
                  $fell(event_input_pin)))
      else $error("pin source mismatch");
   chk_dir_pin: assert property (ce && evt && !tp_on
      && ctrl_q.dir_from_pin && !pin_in && !wrap && !wr_cnt
      |=> cnt_q == $past(cnt_dec))
      else $error("dir pin low did not count down");
   chk_wrap_req: assert property (ce && wrap
      |=> wrap_irq ##1 (wrap_irq == $past(wrap)))
      else $error("request not raised on wrap");

   cov_up_wrap: cover property (ce && wrap && up_w);
   cov_down_wrap: cover property (ce && underflow);
   cov_x4_count: cover property (ce && evt && x4_on && tp_on);
   cov_late_write: cover property (ce && wr_cnt && !early);
endmodule
`default_nettype wire

// file: sim/quad_source.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Pulse source and two-phase encoder on the far side of the pins
// ****************************************************************
module quad_source (
   // Clock
   input wire logic pclk,
   // Phase a drives the event pin, phase b the out/dir pin
   output logic phase_a,
   output logic phase_b
);
   // Both phases idle low; every change lands just after a rising edge
   initial begin
      phase_a = 1'h0;
      phase_b = 1'h0;
   end

   // One pulse on phase a, two cycles high then two low
   task automatic pulse_a();
      @(posedge pclk) phase_a <= 1'h1;
      repeat (2) @(posedge pclk);
      phase_a <= 1'h0;
      repeat (2) @(posedge pclk);
   endtask

   // Static direction level; this side always drives, the pin is input
   task automatic set_b(input logic lvl);
      @(posedge pclk) phase_b <= lvl;
   endtask

   // One quadrature cycle, one pin moving at a time; forward = b leads
   task automatic cycle(input logic fwd);
      logic [7:0] seq;
      seq = fwd ? 8'h78 : 8'hB4;
      for (int s = 0; s < 4; s++) begin
         @(posedge pclk) {phase_a, phase_b} <= seq[7-2*s -: 2];
         repeat (2) @(posedge pclk);
      end
   endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ****************************************************************
   // Signals
   // ****************************************************************
   typedef struct {
      logic [9:0] ctrl;
      logic [15:0] n;
      int ev;
      logic lvl;
      logic [15:0] exp;
      int nw;
   } row_t;
   logic pclk, presetn, psel, penable, pwrite, err, ce;
   logic pready, pslverr, pin_out, pin_oe, wrap_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] nb; // Neighbour wraps: next, prev, b2
   wire logic ph_a;
   wire logic ph_b;
   wire logic pin_w;
   int n_fail = 0;
   int total_checks = 0;
   int n_wraps = 0;
   int base;
   evtcnt_pkg::ctrl_t c;
   // Control, preload, events, dir level or forward, count, wraps
   row_t rows [13] = '{
      '{10'h083, 16'hFFFD, 3, 1'h0, 16'hFFFD, 1},
      '{10'h001, 16'h0002, 3, 1'h0, 16'h0002, 1},
      '{10'h089, 16'h0001, 3, 1'h0, 16'hFFFE, 1},
      '{10'h023, 16'h0000, 2, 1'h0, 16'h0002, 0},
      '{10'h041, 16'h0005, 2, 1'h0, 16'h0003, 0},
      '{10'h063, 16'h0007, 1, 1'h0, 16'h0008, 0},
      '{10'h085, 16'h000A, 2, 1'h1, 16'h000C, 0},
      '{10'h087, 16'h000A, 2, 1'h0, 16'h0008, 0},
      '{10'h082, 16'h0003, 2, 1'h0, 16'h0003, 0},
      '{10'h101, 16'h0010, 2, 1'h1, 16'h0012, 0},
      '{10'h103, 16'h0010, 1, 1'h0, 16'h000F, 0},
      '{10'h301, 16'h0010, 2, 1'h1, 16'h0018, 0},
      '{10'h301, 16'h0001, 1, 1'h0, 16'h0001, 2}};

   // Pin level: the block wins while it drives, else the encoder
   assign pin_w = pin_oe ? pin_out : ph_b;

   event_counter #(.CH(3), .CNT_W(16)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_input_pin(ph_a), .pin_in(pin_w),
      .pin_out(pin_out), .pin_oe(pin_oe), .b2_wrap(nb[0]),
      .prev_wrap(nb[1]), .next_wrap(nb[2]), .wrap_irq(wrap_irq));

   quad_source enc (.pclk(pclk), .phase_a(ph_a), .phase_b(ph_b));

   // ****************************************************************
   // Clock, wrap monitor, watchdog
   // ****************************************************************
   initial begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end

   // Counts request pulses; each lasts one cycle
   always @(posedge pclk) begin
      if (wrap_irq === 1'h1) n_wraps <= n_wraps + 1;
   end

   // The whole run needs well under 10000 cycles
   initial begin
      #200us;
      n_fail++;
      close_out();
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; only the watchdog bounds the wait for pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic rd_reg(input logic [11:0] a);
      apb(1'h0, a, 32'h0);
   endtask

   // Neighbour sources also see pin pulses, which must be ignored
   task automatic events(input evtcnt_pkg::ctrl_t k, input int ev,
                         input logic fwd);
      for (int e = 0; e < ev; e++) begin
         if (k.two_phase) enc.cycle(fwd);
         else if (k.trig_sel == evtcnt_pkg::TRIG_PIN) enc.pulse_a();
         else begin
            @(posedge pclk) nb <= 3'h1 << (k.trig_sel - 2'h1);
            @(posedge pclk) nb <= 3'h0;
            enc.pulse_a();
         end
      end
   endtask

   task automatic close_out();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      nb = 3'h0;
      ce = 1'h1;
      presetn = 1'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      // Table rows: stop, preload while stopped, start, count, compare
      foreach (rows[i]) begin
         c = rows[i].ctrl;
         wr_reg(evtcnt_pkg::CTRL_OFS, 32'h0);
         enc.set_b(c.two_phase ? 1'h0 : rows[i].lvl);
         wr_reg(evtcnt_pkg::COUNT_OFS, {16'h0, rows[i].n});
         wr_reg(evtcnt_pkg::CTRL_OFS, {22'h0, rows[i].ctrl});
         base = n_wraps;
         events(c, rows[i].ev, rows[i].lvl);
         repeat (4) @(posedge pclk);
         rd_reg(evtcnt_pkg::COUNT_OFS);
         chk(rd, {16'h0, rows[i].exp});
         chk(32'(n_wraps - base), 32'(rows[i].nw));
      end
      // Second reset in mid-run brings every register back
      wr_reg(evtcnt_pkg::COUNT_OFS, 32'h1234);
      wr_reg(evtcnt_pkg::CTRL_OFS, 32'h93);
      @(posedge pclk) presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(32'({pready, pslverr, pin_out, pin_oe, wrap_irq}), 32'h0);
      presetn <= 1'h1;
      rd_reg(evtcnt_pkg::CTRL_OFS);
      chk(rd, 32'(evtcnt_pkg::CTRL_RST));
      rd_reg(evtcnt_pkg::COUNT_OFS);
      chk(rd, 32'(evtcnt_pkg::COUNT_RST));
      rd_reg(evtcnt_pkg::STAT_OFS);
      chk(rd, 32'h0);
      // Unmapped word reads zero with an error response
      rd_reg(12'h00C);
      chk({err, rd[30:0]}, 32'h80000000);
      // Writes before and after the first event, pulse output
      wr_reg(evtcnt_pkg::CTRL_OFS, 32'h91);
      wr_reg(evtcnt_pkg::COUNT_OFS, 32'h4);
      rd_reg(evtcnt_pkg::COUNT_OFS);
      chk(rd, 32'h4);
      chk(32'({pin_oe, pin_out}), 32'h2);
      enc.pulse_a();
      rd_reg(evtcnt_pkg::STAT_OFS);
      chk(rd, 32'h3);
      wr_reg(evtcnt_pkg::COUNT_OFS, 32'h8);
      rd_reg(evtcnt_pkg::COUNT_OFS);
      chk(rd, 32'h3);
      repeat (4) enc.pulse_a();
      rd_reg(evtcnt_pkg::COUNT_OFS);
      chk(rd, 32'h8);
      chk(32'({pin_oe, pin_out}), 32'h3);
      // Enable low freezes the counter and its edge detector
      @(posedge pclk) ce <= 1'h0;
      enc.pulse_a();
      @(posedge pclk) ce <= 1'h1;
      rd_reg(evtcnt_pkg::COUNT_OFS);
      chk(rd, 32'h8);
      // Stop: output returns low and pin edges no longer count
      wr_reg(evtcnt_pkg::CTRL_OFS, 32'h90);
      enc.pulse_a();
      chk(32'(pin_out), 32'h0);
      rd_reg(evtcnt_pkg::COUNT_OFS);
      chk(rd, 32'h8);
      close_out();
   end
endmodule
`default_nettype wire
